// File: common/pel_pkg.sv
// Package for the power unit error logger: register map, codes, fields.
// Assumes a 32-bit APB with one aligned word per register.
package pel_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_STATUS_LO = 8'h00;
   localparam logic [7:0] OFS_STATUS_HI = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h0c;
   localparam logic [7:0] OFS_BANK      = 8'h10;
   localparam logic [7:0] OFS_CLEAR     = 8'h14;
   localparam logic [7:0] OFS_DEV_ID    = 8'h18;
   // Machine-check bank that this logger serves
   localparam logic [7:0] BANK_NUM = 8'h04;
   // Identity value, arbitrary
   localparam logic [31:0] DEV_ID = 32'h0000_5e10;
   // Internal error class codes, bits 15:0
   localparam logic [15:0] CLASS_PCU = 16'h0402;
   localparam logic [15:0] CLASS_FW  = 16'h0406;
   // Field positions
   localparam int CLASS_LSB = 0;
   localparam int UC_LSB    = 16;
   localparam int FSM_LSB   = 20;
   // Microcontroller failure codes, bits 19:16
   localparam logic [3:0] UC_NONE      = 4'h0;
   localparam logic [3:0] UC_IADDR     = 4'h1;
   localparam logic [3:0] UC_IFETCH_DB = 4'h2;
   localparam logic [3:0] UC_OPCODE    = 4'h3;
   localparam logic [3:0] UC_STK_UNDER = 4'h4;
   localparam logic [3:0] UC_STK_OVER  = 4'h5;
   localparam logic [3:0] UC_DADDR     = 4'h6;
   localparam logic [3:0] UC_DFETCH_DB = 4'h7;
   // State-machine failure codes, bits 23:20
   localparam logic [3:0] FSM_NONE     = 4'h0;
   localparam logic [3:0] FSM_TIMEOUT  = 4'h4;
   localparam logic [3:0] FSM_SMB_INT  = 4'h5;
   // Interrupt status bit positions
   localparam int IRQ_UC   = 0;
   localparam int IRQ_FSM  = 1;
   localparam int IRQ_FW   = 2;
   localparam int IRQ_W    = 3;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage : pel_pkg

// File: common/pel_evt_if.sv
// Carrier for one encoded error event between encoder and logger core.
// Assumes single clock; all members are driven by the encoder.
`timescale 1ns/100ps
`default_nettype none
interface pel_evt_if;
   logic       valid;
   logic [15:0] class_code;
   logic [3:0]  uc_code;
   logic [3:0]  fsm_code;
   logic        is_fw;
   modport src (output valid, output class_code, output uc_code,
                output fsm_code, output is_fw);
   modport dst (input valid, input class_code, input uc_code,
                input fsm_code, input is_fw);
endinterface : pel_evt_if
`default_nettype wire

// File: hdl/pel_encoder.sv
// Encoder: one-hot failure flags to field codes of the status register.
// Assumes flags come from logic on sys_clk_i, already synchronous.
`timescale 1ns/100ps
`default_nettype none
module pel_encoder
(
   // Clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       reset_i,
   // Failure flags
   input  wire logic [6:0] uc_fail_i,
   input  wire logic [1:0] fsm_fail_i,
   input  wire logic       fw_fail_i,
   // Encoded event
   pel_evt_if.src          evt
);
   // Lowest set flag wins; only defined codes can leave this function
   function automatic logic [3:0] pel_uc_code(input logic [6:0] f);
      logic [3:0] c;
      c = pel_pkg::UC_NONE;
      if (f[0])      c = pel_pkg::UC_IADDR;
      else if (f[1]) c = pel_pkg::UC_IFETCH_DB;
      else if (f[2]) c = pel_pkg::UC_OPCODE;
      else if (f[3]) c = pel_pkg::UC_STK_UNDER;
      else if (f[4]) c = pel_pkg::UC_STK_OVER;
      else if (f[5]) c = pel_pkg::UC_DADDR;
      else if (f[6]) c = pel_pkg::UC_DFETCH_DB;
      return c;
   endfunction : pel_uc_code

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         evt.valid      <= 1'b0;
         evt.class_code <= pel_pkg::CLASS_PCU;
         evt.uc_code    <= pel_pkg::UC_NONE;
         evt.fsm_code   <= pel_pkg::FSM_NONE;
         evt.is_fw      <= 1'b0;
      end
      else
      begin
         evt.valid    <= (|uc_fail_i) | (|fsm_fail_i) | fw_fail_i;
         evt.is_fw    <= fw_fail_i;
         evt.class_code <= fw_fail_i ? pel_pkg::CLASS_FW
                                     : pel_pkg::CLASS_PCU;
         evt.uc_code  <= pel_uc_code(uc_fail_i);
         if (fsm_fail_i[0])
            evt.fsm_code <= pel_pkg::FSM_TIMEOUT;
         else if (fsm_fail_i[1])
            evt.fsm_code <= pel_pkg::FSM_SMB_INT;
         else
            evt.fsm_code <= pel_pkg::FSM_NONE;
      end
   end

   a_uc_defined: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      evt.uc_code <= pel_pkg::UC_DFETCH_DB)
      else $error("undefined controller code");
   a_uc_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (uc_fail_i == 7'h00) |=> (evt.uc_code == pel_pkg::UC_NONE))
      else $error("controller field not zero without failure");
endmodule : pel_encoder
`default_nettype wire

// File: hdl/pel_apb_slave.sv
// APB slave front end: one-cycle ready, decode passed to the core.
// Assumes APB3 master on sys_clk_i; data 32 bits, byte addresses.
`timescale 1ns/100ps
`default_nettype none
module pel_apb_slave
(
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   // APB
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   output logic             access_o,
   output logic             pready_o
);
   // Zero wait states: ready rises in the first access cycle
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         pready_o <= 1'b0;
      else
         pready_o <= psel_i & ~penable_i;
   end
   assign access_o = psel_i & penable_i & pready_o;
endmodule : pel_apb_slave
`default_nettype wire

// File: hdl/pel_logger.sv
// Power unit error logger top: encoder, status register, APB registers.
// Assumes failure flags are synchronous to sys_clk_i; APB on same clock.
`timescale 1ns/100ps
`default_nettype none
module pel_logger
(
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   // Failure flags
   input  wire logic [6:0]  uc_fail_i,
   input  wire logic [1:0]  fsm_fail_i,
   input  wire logic        fw_fail_i,
   // APB
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Interrupt
   output logic             irq_o
);
   pel_evt_if evt ();
   logic              access;
   logic [63:0]       bank_four_error_status;
   logic [pel_pkg::IRQ_W-1:0] irq_stat;
   logic [pel_pkg::IRQ_W-1:0] irq_mask;
   logic [pel_pkg::IRQ_W-1:0] next_irq_ev;
   logic              rd_stat;
   logic              wr_clear;
   logic              wr_mask;
   logic [pel_pkg::IRQ_W-1:0] mask_wdata;

   pel_encoder u_enc
   (
      .sys_clk_i  (sys_clk_i),
      .reset_i    (reset_i),
      .uc_fail_i  (uc_fail_i),
      .fsm_fail_i (fsm_fail_i),
      .fw_fail_i  (fw_fail_i),
      .evt        (evt)
   );

   pel_apb_slave u_apb
   (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .psel_i    (psel_i),
      .penable_i (penable_i),
      .access_o  (access),
      .pready_o  (pready_o)
   );

   // Register hit by the access cycle of a transfer
   function automatic logic pel_hit(input logic acc, input logic [7:0] a,
                                    input logic [7:0] ofs);
      return acc && (a == ofs);
   endfunction : pel_hit

   assign rd_stat  = ~pwrite_i &
                     pel_hit(access, paddr_i, pel_pkg::OFS_IRQ_STAT);
   assign wr_clear = pwrite_i &
                     pel_hit(access, paddr_i, pel_pkg::OFS_CLEAR);
   assign wr_mask  = pwrite_i &
                     pel_hit(access, paddr_i, pel_pkg::OFS_IRQ_MASK);
   assign mask_wdata = pwdata_i[pel_pkg::IRQ_W-1:0];
   assign next_irq_ev = {evt.valid & evt.is_fw,
                         evt.valid & (evt.fsm_code != pel_pkg::FSM_NONE),
                         evt.valid & (evt.uc_code != pel_pkg::UC_NONE)};

   // Status register: first error since clear is kept; field zero if unused
   // An error in the clearing cycle is logged rather than lost
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         bank_four_error_status <= 64'h0000_0000_0000_0000;
      else if (evt.valid && ((bank_four_error_status == 64'h0) || wr_clear))
      begin
         bank_four_error_status <= 64'h0;
         bank_four_error_status[pel_pkg::CLASS_LSB +: 16] <=
            evt.class_code;
         bank_four_error_status[pel_pkg::UC_LSB +: 4] <=
            evt.uc_code;
         bank_four_error_status[pel_pkg::FSM_LSB +: 4] <=
            evt.fsm_code;
      end
      else if (wr_clear)
         bank_four_error_status <= 64'h0;
   end

   // Sticky interrupt status: read clears, a new event in that cycle wins
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         irq_stat <= '0;
      else
         irq_stat <= (rd_stat ? '0 : irq_stat) | next_irq_ev;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         irq_mask <= '0;
      else if (wr_mask)
         irq_mask <= mask_wdata;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(((rd_stat ? '0 : irq_stat) | next_irq_ev) & irq_mask);
   end

   // Read data and error answer
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         prdata_o  <= pel_pkg::RESET_WORD;
         pslverr_o <= 1'b0;
      end
      else if (psel_i && !penable_i)
      begin
         pslverr_o <= 1'b0;
         prdata_o  <= pel_pkg::RESET_WORD;
         if (paddr_i == pel_pkg::OFS_STATUS_LO)
            prdata_o <= bank_four_error_status[31:0];
         else if (paddr_i == pel_pkg::OFS_STATUS_HI)
            prdata_o <= bank_four_error_status[63:32];
         else if (paddr_i == pel_pkg::OFS_IRQ_STAT)
            // An event at the setup edge is reported before the read clears
            prdata_o <= {{(32-pel_pkg::IRQ_W){1'b0}}, irq_stat | next_irq_ev};
         else if (paddr_i == pel_pkg::OFS_IRQ_MASK)
            prdata_o <= {{(32-pel_pkg::IRQ_W){1'b0}}, irq_mask};
         else if (paddr_i == pel_pkg::OFS_BANK)
            prdata_o <= {24'h00_0000, pel_pkg::BANK_NUM};
         else if (paddr_i == pel_pkg::OFS_DEV_ID)
            prdata_o <= pel_pkg::DEV_ID;
         else if (paddr_i != pel_pkg::OFS_CLEAR)
            pslverr_o <= 1'b1;
      end
   end

   a_class_legal: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (bank_four_error_status != 64'h0) |->
      (bank_four_error_status[15:0] == pel_pkg::CLASS_PCU ||
       bank_four_error_status[15:0] == pel_pkg::CLASS_FW))
      else $error("class code not legal");
   a_uc_field: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (bank_four_error_status == 64'h0 && uc_fail_i[2] && !uc_fail_i[1]
       && !uc_fail_i[0]) |-> ##2
      (bank_four_error_status[19:16] == pel_pkg::UC_OPCODE))
      else $error("opcode failure not logged");
   a_uc_stack: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (bank_four_error_status == 64'h0 && uc_fail_i == 7'h10) |-> ##2
      (bank_four_error_status[19:16] == pel_pkg::UC_STK_OVER))
      else $error("stack overflow not logged");
   a_uc_range: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      bank_four_error_status[19:16] <= pel_pkg::UC_DFETCH_DB)
      else $error("controller field out of range");
   a_fsm_legal: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      bank_four_error_status[23:20] == pel_pkg::FSM_NONE ||
      bank_four_error_status[23:20] == pel_pkg::FSM_TIMEOUT ||
      bank_four_error_status[23:20] == pel_pkg::FSM_SMB_INT)
      else $error("state-machine field reserved code");
   a_fsm_timeout: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (bank_four_error_status == 64'h0 && fsm_fail_i[0]) |-> ##2
      (bank_four_error_status[23:20] == pel_pkg::FSM_TIMEOUT))
      else $error("timeout not logged");
   a_fsm_sep: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (bank_four_error_status == 64'h0 && fsm_fail_i != 2'b00 &&
       uc_fail_i == 7'h00) |-> ##2
      (bank_four_error_status[19:16] == pel_pkg::UC_NONE &&
       bank_four_error_status[23:20] != pel_pkg::FSM_NONE))
      else $error("fields not separate");
   a_bank_four: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (access && !pwrite_i && paddr_i == pel_pkg::OFS_BANK) |->
      (prdata_o == 32'h0000_0004))
      else $error("bank number not four");
   a_zero_idle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (bank_four_error_status == 64'h0 && !fw_fail_i && uc_fail_i == 7'h00
       && fsm_fail_i[0] && !fsm_fail_i[1]) |-> ##2
      (bank_four_error_status[19:16] == 4'h0))
      else $error("unused field not zero");

   // Interrupt status, mask and level output
   a_irq_sticky: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !rd_stat |=> ((irq_stat & $past(irq_stat)) == $past(irq_stat)))
      else $error("interrupt status bit lost");
   a_irq_set: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      1'b1 |=> ((irq_stat & $past(next_irq_ev)) == $past(next_irq_ev)))
      else $error("interrupt event not recorded");
   a_irq_rdclr: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (rd_stat && next_irq_ev == '0) |=> (irq_stat == '0))
      else $error("interrupt status not cleared by read");
   a_irq_level: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      1'b1 |=> (irq_o == |(irq_stat & $past(irq_mask))))
      else $error("interrupt output disagrees with status");
   a_mask_write: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      wr_mask |=> (irq_mask == $past(mask_wdata)))
      else $error("mask write not taken");

   // Bus answer
   a_ready_setup: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (psel_i && !penable_i) |=> pready_o)
      else $error("ready missing in access cycle");
   a_ready_once: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_no_err: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (psel_i && !penable_i && paddr_i == pel_pkg::OFS_STATUS_LO)
      |=> !pslverr_o)
      else $error("error answer on mapped register");
   a_dev_id: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (access && !pwrite_i && paddr_i == pel_pkg::OFS_DEV_ID) |->
      (prdata_o == pel_pkg::DEV_ID))
      else $error("identity read wrong");

   // Status register keeping and clearing
   a_status_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (bank_four_error_status != 64'h0 && !wr_clear) |=>
      $stable(bank_four_error_status))
      else $error("logged error overwritten");
   a_status_clr: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (wr_clear && !evt.valid) |=> (bank_four_error_status == 64'h0))
      else $error("status not cleared");
   a_high_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      bank_four_error_status[63:32] == 32'h0)
      else $error("high status word not zero");

   // Field codes against the failure flags
   a_log_first: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (evt.valid && bank_four_error_status == 64'h0) |=>
      (bank_four_error_status[15:0] == $past(evt.class_code)))
      else $error("class code not logged");
   a_fw_class: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (bank_four_error_status == 64'h0 && fw_fail_i) |-> ##2
      (bank_four_error_status[15:0] == pel_pkg::CLASS_FW))
      else $error("firmware class not logged");
   a_pcu_class: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (bank_four_error_status == 64'h0 && !fw_fail_i &&
       (uc_fail_i != 7'h00 || fsm_fail_i != 2'b00)) |-> ##2
      (bank_four_error_status[15:0] == pel_pkg::CLASS_PCU))
      else $error("power unit class not logged");
   a_iaddr_code: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (bank_four_error_status == 64'h0 && uc_fail_i[0]) |-> ##2
      (bank_four_error_status[19:16] == pel_pkg::UC_IADDR))
      else $error("instruction address failure not logged");
   a_ifetch_code: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (bank_four_error_status == 64'h0 && uc_fail_i == 7'h02) |-> ##2
      (bank_four_error_status[19:16] == pel_pkg::UC_IFETCH_DB))
      else $error("instruction fetch failure not logged");
   a_under_code: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (bank_four_error_status == 64'h0 && uc_fail_i == 7'h08) |-> ##2
      (bank_four_error_status[19:16] == pel_pkg::UC_STK_UNDER))
      else $error("stack underflow not logged");
   a_daddr_code: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (bank_four_error_status == 64'h0 && uc_fail_i == 7'h20) |-> ##2
      (bank_four_error_status[19:16] == pel_pkg::UC_DADDR))
      else $error("data address failure not logged");
   a_dram_code: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (bank_four_error_status == 64'h0 && uc_fail_i == 7'h40) |-> ##2
      (bank_four_error_status[19:16] == pel_pkg::UC_DFETCH_DB))
      else $error("data fetch failure not logged");
   a_smb_code: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (bank_four_error_status == 64'h0 && fsm_fail_i == 2'b10) |-> ##2
      (bank_four_error_status[23:20] == pel_pkg::FSM_SMB_INT))
      else $error("bus controller interrupt not logged");
endmodule : pel_logger
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the power unit error logger top.
// Assumes pel_pkg is compiled first; drives APB and failure flags.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        sys_clk_i  = 1'b0;
   logic        reset_i    = 1'b1;
   logic [6:0]  uc_fail_i  = 7'h00;
   logic [1:0]  fsm_fail_i = 2'h0;
   logic        fw_fail_i  = 1'b0;
   logic        psel_i     = 1'b0;
   logic        penable_i  = 1'b0;
   logic        pwrite_i   = 1'b0;
   logic [7:0]  paddr_i    = 8'h00;
   logic [31:0] pwdata_i   = 32'h0;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        irq_o;
   int          fail_count = 0;
   int          n_compared = 0;
   logic [31:0] rd;
   logic        er;
   logic [6:0]  ru;
   logic [1:0]  rs;
   logic        rf;

   always #4 sys_clk_i = ~sys_clk_i;

   pel_logger dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .uc_fail_i(uc_fail_i), .fsm_fail_i(fsm_fail_i),
      .fw_fail_i(fw_fail_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .irq_o(irq_o));

   task automatic complete_run;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch t=%0t word got %h exp %h", $time, got, exp);
      end
   endtask : chk32

   task automatic chk1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch t=%0t bit got %b exp %b", $time, got, exp);
      end
   endtask : chk1

   // Held until pready is seen high at the sampling edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do
      begin
         @(posedge sys_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      if (n >= 50)
         chk1(1'b0, 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   function automatic logic [31:0] exp_status(input logic [6:0] uc,
      input logic [1:0] fsm, input logic fw);
      logic [31:0] s;
      logic [3:0]  u;
      s = 32'h0;
      u = 4'h0;
      for (int i = 6; i >= 0; i--)
         if (uc[i])
            u = 4'(i + 1);
      s[15:0]  = fw ? pel_pkg::CLASS_FW : pel_pkg::CLASS_PCU;
      s[19:16] = u;
      s[23:20] = fsm[0] ? pel_pkg::FSM_TIMEOUT :
                 (fsm[1] ? pel_pkg::FSM_SMB_INT : pel_pkg::FSM_NONE);
      return s;
   endfunction : exp_status

   function automatic logic [31:0] exp_irq(input logic [6:0] uc,
      input logic [1:0] fsm, input logic fw);
      logic [31:0] s;
      s = 32'h0;
      s[pel_pkg::IRQ_UC]  = (uc != 7'h00);
      s[pel_pkg::IRQ_FSM] = (fsm != 2'h0);
      s[pel_pkg::IRQ_FW]  = fw;
      return s;
   endfunction : exp_irq

   task automatic pulse(input logic [6:0] uc, input logic [1:0] fsm,
                        input logic fw);
      @(posedge sys_clk_i);
      uc_fail_i  <= uc;
      fsm_fail_i <= fsm;
      fw_fail_i  <= fw;
      @(posedge sys_clk_i);
      uc_fail_i  <= 7'h00;
      fsm_fail_i <= 2'h0;
      fw_fail_i  <= 1'b0;
   endtask : pulse

   // One event, both status words checked, then status and irq cleared
   task automatic log_one(input logic [6:0] uc, input logic [1:0] fsm,
                          input logic fw);
      logic [31:0] r;
      logic        e;
      pulse(uc, fsm, fw);
      apb(1'b0, pel_pkg::OFS_STATUS_LO, 32'h0, r, e);
      chk32(r, exp_status(uc, fsm, fw));
      apb(1'b0, pel_pkg::OFS_STATUS_HI, 32'h0, r, e);
      chk32(r, 32'h0);
      apb(1'b1, pel_pkg::OFS_CLEAR, 32'h1, r, e);
      apb(1'b0, pel_pkg::OFS_IRQ_STAT, 32'h0, r, e);
      chk32(r, exp_irq(uc, fsm, fw));
   endtask : log_one

   initial
   begin
      repeat (20000) @(posedge sys_clk_i);
      fail_count++;
      complete_run();
   end

   initial
   begin
      void'($urandom(32'h9808090b));
      repeat (2) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      apb(1'b0, pel_pkg::OFS_STATUS_LO, 32'h0, rd, er);
      chk32(rd, 32'h0);
      apb(1'b0, pel_pkg::OFS_BANK, 32'h0, rd, er);
      chk32(rd, 32'(pel_pkg::BANK_NUM));
      apb(1'b1, pel_pkg::OFS_BANK, 32'hff, rd, er);
      apb(1'b0, pel_pkg::OFS_BANK, 32'h0, rd, er);
      chk32(rd, 32'(pel_pkg::BANK_NUM));
      apb(1'b0, 8'h40, 32'h0, rd, er);
      chk1(er, 1'b1);
      chk32(rd, 32'h0);
      apb(1'b0, pel_pkg::OFS_DEV_ID, 32'h0, rd, er);
      chk32(rd, pel_pkg::DEV_ID);
      chk1(er, 1'b0);
      for (int k = 0; k < 7; k++)
         log_one(7'(1 << k), 2'h0, 1'b0);
      for (int k = 0; k < 3; k++)
         log_one(7'h00, 2'(k + 1), 1'b0);
      log_one(7'h00, 2'h1, 1'b1);
      for (int k = 0; k < 20; k++)
      begin
         ru = 7'($urandom);
         rs = 2'($urandom);
         rf = 1'($urandom);
         if (ru == 7'h00)
            ru = 7'h40;
         log_one(ru, rs, rf);
      end
      // First error stays; a later one must not overwrite it
      pulse(7'h04, 2'h0, 1'b0);
      pulse(7'h00, 2'h2, 1'b1);
      apb(1'b0, pel_pkg::OFS_STATUS_LO, 32'h0, rd, er);
      chk32(rd, exp_status(7'h04, 2'h0, 1'b0));
      apb(1'b1, pel_pkg::OFS_CLEAR, 32'h0, rd, er);
      apb(1'b0, pel_pkg::OFS_STATUS_LO, 32'h0, rd, er);
      chk32(rd, 32'h0);
      // Interrupt: enabled source raises, read clears, masked one stays low
      apb(1'b0, pel_pkg::OFS_IRQ_STAT, 32'h0, rd, er);
      apb(1'b1, pel_pkg::OFS_IRQ_MASK, 32'h1, rd, er);
      apb(1'b0, pel_pkg::OFS_IRQ_MASK, 32'h0, rd, er);
      chk32(rd, 32'h1);
      pulse(7'h01, 2'h0, 1'b0);
      repeat (3) @(posedge sys_clk_i);
      chk1(irq_o, 1'b1);
      apb(1'b0, pel_pkg::OFS_IRQ_STAT, 32'h0, rd, er);
      chk32(rd, 32'h1);
      repeat (2) @(posedge sys_clk_i);
      chk1(irq_o, 1'b0);
      apb(1'b1, pel_pkg::OFS_CLEAR, 32'h0, rd, er);
      pulse(7'h00, 2'h1, 1'b0);
      repeat (3) @(posedge sys_clk_i);
      chk1(irq_o, 1'b0);
      apb(1'b0, pel_pkg::OFS_IRQ_STAT, 32'h0, rd, er);
      chk32(rd, 32'h2);
      // Reset in mid-run drops the logged error, the mask and the output
      pulse(7'h20, 2'h2, 1'b0);
      repeat (2) @(posedge sys_clk_i);
      chk1(irq_o, 1'b1);
      reset_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      chk1(irq_o, 1'b0);
      apb(1'b0, pel_pkg::OFS_STATUS_LO, 32'h0, rd, er);
      chk32(rd, 32'h0);
      apb(1'b0, pel_pkg::OFS_IRQ_MASK, 32'h0, rd, er);
      chk32(rd, 32'h0);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
